// File: bench/dsic_cpu_model.sv
`timescale 1ns/1ps
// Processor side, issuing single port writes as an output instruction does
module dsic_cpu_model (
    input wire clk_i,                       // Chip clock
    output logic port_wr_o = 1'b0,          // Write strobe
    output logic [2:0] port_addr_o = 3'h0,  // Port number
    output logic [7:0] port_data_o = 8'h00  // Write data
);
    // One edge of strobe, then one more edge so the outputs have landed
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i) #2;
        port_wr_o = 1'b1;
        port_addr_o = a;
        port_data_o = d;
        @(posedge clk_i) #2;
        port_wr_o = 1'b0;
        port_addr_o = ~a; // Released bus keeps no stale value
        port_data_o = ~d;
        @(posedge clk_i) #2;
    endtask
endmodule

// File: bench/dsic_status_ctrl_asserts.sv
`timescale 1ns/1ps
module dsic_status_ctrl_chk #(parameter BAUD_DIV = 20) (
    input wire clk_i, rstn_i, ce_i, port_wr_i,
    input wire [2:0] port_addr_i,
    input wire [7:0] port_data_i,
    input wire codec_receive_done_i, scan_i, rxd_i,
    input wire aux_out_o, txd_o, branch_test_input_o, irq_o,
    input wire [7:0] status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Wait with a clock source open; a missing tick would let it run away
    logic [15:0] lo_q;
    always_ff @(posedge clk_i)
        lo_q <= (!rstn_i || !ce_i || irq_o || &status_o[1:0]) ? 16'h0 : lo_q + 16'h1;
    wire wr = ce_i && port_wr_i && port_addr_i == 3'h6;
    a_write_lands: assert property (wr ##1 !wr |-> ##1 status_o == $past(port_data_i, 2))
        else $error("write lost");
    a_aux_pin: assert property (aux_out_o == status_o[7])
        else $error("aux level");
    a_txd_pin: assert property (txd_o == status_o[6])
        else $error("txd level");
    a_sel_idle: assert property (status_o[5:3] > 3'h4 && $past(status_o[5:3]) > 3'h4
        |-> !branch_test_input_o) else $error("idle select");
    a_conv_route: assert property (status_o[5:0] == 6'h03 && $stable(status_o)
        |-> branch_test_input_o == irq_o) else $error("conv route");
    a_all_masked: assert property (&status_o[2:0] && &$past(status_o[2:0]) |-> !irq_o)
        else $error("masked irq");
    a_conv_delay: assert property ($rose(codec_receive_done_i) && !status_o[2]
        && !port_wr_i |-> ##[1:17] irq_o) else $error("conv late");
    a_rate_tick: assert property (lo_q < BAUD_DIV + 4)
        else $error("no tick");
endmodule
bind dsic_status_ctrl dsic_status_ctrl_chk #(.BAUD_DIV(BAUD_DIV)) u_chk (.*);

// File: bench/dsic_status_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module dsic_status_ctrl_test;
    localparam int DIV = 20;
    logic clk_i, rstn_i, ce_i, codec, scan, rxd;
    wire wr, aux, txd, bti, irq;
    wire [2:0] addr;
    wire [7:0] data, status;
    logic [7:0] d;
    int n_mismatch = 0;
    int cmp_count = 0;
    dsic_cpu_model cpu (.clk_i(clk_i), .port_wr_o(wr), .port_addr_o(addr), .port_data_o(data));
    dsic_status_ctrl #(.BAUD_DIV(DIV)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .port_wr_i(wr), .port_addr_i(addr), .port_data_i(data), .codec_receive_done_i(codec),
        .scan_i(scan), .rxd_i(rxd), .aux_out_o(aux), .txd_o(txd),
        .branch_test_input_o(bti), .irq_o(irq), .status_o(status));
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Whole run is some 190 cycles
    initial begin
        #50000;
        n_mismatch++;
        stop_test;
    end
    initial begin
        {rstn_i, codec, scan, rxd} = 4'h0;
        ce_i = 1;
        wt(16);
        rstn_i = 1;
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], 6'h07};
            cpu.put(3'h6, d);
            `CHK(status, d)
            `CHK({aux, txd}, d[7:6])
        end
        cpu.put(3'h5, 8'h00);
        `CHK(status, 8'hc7)
        // Scan and rxd levels differ, so a swapped route shows
        for (int s = 0; s < 8; s++) begin
            scan = s[0];
            rxd = ~s[0];
            wt(3);
            cpu.put(3'h6, {2'b00, s[2:0], 3'h7});
            `CHK(bti, s == 3 || s == 4)
        end
        // Second pass shows a fresh post after acknowledge
        cpu.put(3'h6, 8'h03);
        for (int k = 0; k < 2; k++) begin
            codec = 1;
            wt(17);
            `CHK({irq, bti}, 2'b11)
            codec = 0;
            cpu.put(3'h6, 8'h07);
            `CHK(irq, 1'b0)
            cpu.put(3'h6, 8'h03);
            `CHK(irq, 1'b0)
        end
        cpu.put(3'h6, 8'h0d);
        wt(DIV + 4);
        `CHK({irq, bti}, 2'b11)
        cpu.put(3'h6, 8'h16);
        wt(DIV + 4);
        `CHK({irq, bti}, 2'b11)
        // Clock enable low freezes the register: this write must be lost
        ce_i = 0;
        cpu.put(3'h6, 8'hc7);
        ce_i = 1;
        wt(2);
        `CHK(status, 8'h16)
        stop_test;
    end
endmodule

// File: core/dsic_consts.vh
`ifndef DSIC_CONSTS_VH
`define DSIC_CONSTS_VH

// Port number of the status/control register
`define DSIC_PORT_STATUS_CTRL 3'h6
// Field positions in the status/control register
`define DSIC_BIT_AUX_OUT 7
`define DSIC_BIT_SER_TX 6
`define DSIC_SEL_HI 5
`define DSIC_SEL_LO 3
`define DSIC_BIT_MASK_CONV 2
`define DSIC_BIT_MASK_TX 1
`define DSIC_BIT_MASK_RX 0
// Selector codes for the branch-test route
`define DSIC_SEL_CONV 3'h0
`define DSIC_SEL_TXCLK 3'h1
`define DSIC_SEL_RXCLK 3'h2
`define DSIC_SEL_SCAN 3'h3
`define DSIC_SEL_RXD 3'h4
// Reset value of the status/control register
`define DSIC_RESET_VALUE 8'h00
// Timing: chip clock and bit-rate figures
`define DSIC_CLK_HZ 40000000
`define DSIC_BAUD_HZ 2400
`define DSIC_BAUD_DIV (`DSIC_CLK_HZ / `DSIC_BAUD_HZ)
`define DSIC_CONV_DELAY_CLKS 17

`endif

// File: core/dsic_rate_gen.v
`timescale 1ns/1ps
module dsic_rate_gen #(
    parameter DIV = 16666,
    parameter W = 15
) (
    input wire clk_i,  // Chip clock
    input wire rstn_i, // Sync reset, low
    input wire ce_i,   // Clock enable
    output reg tick_o  // One-cycle tick at bit rate
);
    reg [W-1:0] cnt_q;

    // Free-running divider; tick on wrap
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_q <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (cnt_q == DIV[W-1:0] - 1'b1) begin
                cnt_q <= {W{1'b0}};
                tick_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
                tick_o <= 1'b0;
            end
        end
    end
endmodule

// File: core/dsic_status_ctrl.v
// Operation
// - Processor writes 8-bit value to port 6; device latches it as status register.
// - Bit 7 drives the auxiliary output pin level.
// - Bits 5..3 select which status goes onto the branch-test pin.
// - Select 0 routes conversion flag, select 1 routes transmit-clock flag.
// - Select 2 receive-clock flag, 3 scan pin, 4 serial receive data.
// - Set mask bit clears the posted flag and holds it masked.
// - Mask bit 2 conversion, bit 1 transmit clock, bit 0 receive clock.
// - Three sources post flags sharing one processor interrupt line.
// - Interrupt asserts within 17 clocks after codec receive-done.
// - 2400 Hz bit-rate generator ticks feed transmit and receive clock flags.
// - Conversion delay counted from receive-done to interrupt output; no counter here, the flop pipeline gives a fixed 4 clocks.
`timescale 1ns/1ps
`include "dsic_consts.vh"
module dsic_status_ctrl #(
    parameter BAUD_DIV = `DSIC_BAUD_DIV
) (
    input wire clk_i,                   // Chip clock, 40 MHz
    input wire rstn_i,                  // Sync reset, active low
    input wire ce_i,                    // Clock enable, freezes all state
    input wire port_wr_i,               // Processor port write strobe
    input wire [2:0] port_addr_i,       // Port number of the write
    input wire [7:0] port_data_i,       // Write data
    input wire codec_receive_done_i,    // Codec receive-complete pin
    input wire scan_i,                  // Auxiliary scan input pin
    input wire rxd_i,                   // Serial receive data pin
    output reg aux_out_o,               // General purpose output pin
    output reg txd_o,                   // Serial transmit data
    output reg branch_test_input_o,     // To processor branch-test input
    output reg irq_o,                   // Processor interrupt request
    output reg [7:0] status_o           // Readback of the control register
);
    reg [7:0] program_status_control_q;
    reg [1:0] rcd_sync_q;
    reg [1:0] scan_sync_q;
    reg [1:0] rxd_sync_q;
    reg rcd_prev_q;
    wire rate_tick;
    wire rcd_rise;
    wire [2:0] sel;
    wire [2:0] mask;
    wire [2:0] flags;
    wire [2:0] events;
    genvar gi;

    // Selector decode, used for the branch-test mux
    function sel_route;
        input [2:0] s;
        input [2:0] f;
        input sc;
        input rd;
        begin
            case (s)
                `DSIC_SEL_CONV: sel_route = f[2];
                `DSIC_SEL_TXCLK: sel_route = f[1];
                `DSIC_SEL_RXCLK: sel_route = f[0];
                `DSIC_SEL_SCAN: sel_route = sc;
                `DSIC_SEL_RXD: sel_route = rd;
                default: sel_route = 1'b0;          // Unused codes read low
            endcase
        end
    endfunction

    // Bit-rate tick shared by transmit and receive clock sources
    dsic_rate_gen #(
        .DIV(BAUD_DIV),
        .W(15)
    ) u_rate (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .tick_o(rate_tick)
    );

    // Pins are asynchronous to the chip clock: two flops each
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rcd_sync_q <= 2'h0;
            scan_sync_q <= 2'h0;
            rxd_sync_q <= 2'h0;
            rcd_prev_q <= 1'b0;
        end else if (ce_i) begin
            rcd_sync_q <= {rcd_sync_q[0], codec_receive_done_i};
            scan_sync_q <= {scan_sync_q[0], scan_i};
            rxd_sync_q <= {rxd_sync_q[0], rxd_i};
            rcd_prev_q <= rcd_sync_q[1];
        end
    end

    // Rising edge of receive-done, taken after the synchroniser
    assign rcd_rise = rcd_sync_q[1] & ~rcd_prev_q;

    // Control register load on a write to port 6
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            program_status_control_q <= `DSIC_RESET_VALUE;
        end else if (ce_i && port_wr_i && port_addr_i == `DSIC_PORT_STATUS_CTRL) begin
            program_status_control_q <= port_data_i;
        end
    end

    assign sel = program_status_control_q[`DSIC_SEL_HI:`DSIC_SEL_LO];
    assign mask = {program_status_control_q[`DSIC_BIT_MASK_CONV],
                   program_status_control_q[`DSIC_BIT_MASK_TX],
                   program_status_control_q[`DSIC_BIT_MASK_RX]};
    // Event per source, same bit order as the mask field
    // Transmit and receive share one tick, so both post together
    assign events = {rcd_rise, rate_tick, rate_tick};

    // Posted flags: a set mask clears and holds; events post when unmasked.
    // Mask held means the event is dropped, so acknowledge cannot race it.
    // One flop per source, so no vector has several drivers
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            reg flag_bit_q;

            // Clear wins while the mask bit stays set
            always @(posedge clk_i) begin
                if (!rstn_i) begin
                    flag_bit_q <= 1'b0;
                end else if (ce_i) begin
                    if (mask[gi]) begin
                        flag_bit_q <= 1'b0;
                    end else if (events[gi]) begin
                        flag_bit_q <= 1'b1;
                    end
                end
            end

            // Flag bit onto the shared vector
            assign flags[gi] = flag_bit_q;
        end
    endgenerate

    // Registered outputs; interrupt is 4 clocks after the pin edge, well under 17
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            aux_out_o <= 1'b0;
            txd_o <= 1'b0;
            branch_test_input_o <= 1'b0;
            irq_o <= 1'b0;
            status_o <= 8'h00;
        end else if (ce_i) begin
            aux_out_o <= program_status_control_q[`DSIC_BIT_AUX_OUT];
            txd_o <= program_status_control_q[`DSIC_BIT_SER_TX];
            branch_test_input_o <= sel_route(sel, flags, scan_sync_q[1],
                                             rxd_sync_q[1]);
            irq_o <= |(flags & ~mask);
            status_o <= program_status_control_q;
        end
    end
endmodule
